// file: rtl/nad_pkg.sv
// Purpose: Shared constants and types for the node address pin decoder.
// Assumes: Pin levels arrive as unsigned millivolt samples, one per pin.
// Notes: Register offsets are byte addresses on a 32-bit APB bus.
package nad_pkg;

  // ----------------------------------------------------------------------
  // Level quantisation
  // ----------------------------------------------------------------------
  localparam int unsigned NAD_MV_W = 12;
  localparam int unsigned NAD_CODE_W = 3;
  localparam int unsigned NAD_NUM_BANDS = 7;
  // Upper edge of each band in millivolts, lowest first.
  localparam logic [NAD_NUM_BANDS*NAD_MV_W-1:0] NAD_BAND_TOP_MV = {
    12'hC94, 12'hBC2, 12'hABE, 12'h97E, 12'h7DA, 12'h582, 12'h212};
  localparam logic [NAD_MV_W-1:0] NAD_FULL_SCALE_MV = 12'hCE4;

  // ----------------------------------------------------------------------
  // Address composition
  // ----------------------------------------------------------------------
  localparam int unsigned NAD_ADDR_W = 9;
  localparam logic [NAD_ADDR_W-1:0] NAD_HIGH_WEIGHT = 9'h040;
  localparam logic [NAD_ADDR_W-1:0] NAD_MID_WEIGHT = 9'h006;
  localparam logic [NAD_ADDR_W-1:0] NAD_OPEN_ADDR = 9'h0FF;
  localparam logic [NAD_ADDR_W-1:0] NAD_ADDR_RESET = 9'h000;
  localparam int unsigned NAD_ADDR_TOP_BIT = 8;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned NAD_CLK_MHZ = 250;
  localparam int unsigned NAD_SETTLE_US = 100;
  localparam int unsigned NAD_SETTLE_CYC = NAD_SETTLE_US * NAD_CLK_MHZ;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] NAD_OFS_ADDR = 8'h00;
  localparam logic [7:0] NAD_OFS_STATUS = 8'h04;
  localparam logic [7:0] NAD_OFS_CTRL = 8'h08;
  localparam logic [7:0] NAD_OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] NAD_OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] NAD_OFS_ALIAS = 8'h14;
  localparam int unsigned NAD_ST_READY_BIT = 0;
  localparam int unsigned NAD_ST_FAULT_BIT = 1;
  localparam int unsigned NAD_ST_OPEN_BIT = 2;
  localparam int unsigned NAD_CTRL_ERR_BIT = 0;
  localparam int unsigned NAD_CTRL_CLR_BIT = 1;
  localparam int unsigned NAD_IRQ_W = 3;
  localparam int unsigned NAD_IRQ_READY_BIT = 0;
  localparam int unsigned NAD_IRQ_FAULT_BIT = 1;
  localparam int unsigned NAD_IRQ_OPEN_BIT = 2;
  localparam logic [15:0] NAD_ALIAS_RESET = 16'h0000;

  typedef enum logic [1:0] {
    NAD_SETTLE = 2'b00,
    NAD_SAMPLE = 2'b01,
    NAD_RUN = 2'b11
  } nad_state_t;

  typedef struct packed {
    logic [NAD_MV_W-1:0] high_mv;
    logic [NAD_MV_W-1:0] mid_mv;
    logic [NAD_MV_W-1:0] low_mv;
  } nad_levels_t;

  typedef struct packed {
    logic [NAD_CODE_W-1:0] high;
    logic [NAD_CODE_W-1:0] mid;
    logic [NAD_CODE_W-1:0] low;
  } nad_codes_t;

endpackage

// file: rtl/nad_quantizer.sv
// Purpose: Quantises one pin level in millivolts into a 3-bit band code.
// Assumes: Level is synchronous to pclk and already digitised.
// Notes: Purely combinational; the caller registers the address built from the code.
module nad_quantizer
  import nad_pkg::*;
(
  input wire logic [NAD_MV_W-1:0] level_mv,
  output logic [NAD_CODE_W-1:0] code
);

  // ----------------------------------------------------------------------
  // Band search
  // ----------------------------------------------------------------------
  // The code is the count of band edges lying below the level.
  logic [NAD_NUM_BANDS-1:0] above;

  genvar gi;
  generate
    for (gi = 0; gi < NAD_NUM_BANDS; gi++) begin : g_edge
      assign above[gi] = level_mv > NAD_BAND_TOP_MV[gi*NAD_MV_W +: NAD_MV_W];
    end
  endgenerate

  always_comb begin
    code = '0;
    for (int i = 0; i < NAD_NUM_BANDS; i++) begin
      code = code + NAD_CODE_W'(above[i]);
    end
  end

endmodule // nad_quantizer

// file: rtl/nad_top.sv
// Purpose: Node address pin decoder with APB registers and status indicators.
// Assumes: APB master follows the usual setup and access phases.
// Notes: Pins are sampled once after a settle time; the address then holds.
//
// Summary of operation
// - Each pin level maps to a 3-bit code through ascending voltage bands.
// - Address equals 64 times high code plus 6 times mid plus low.
// - All pins open or grounded gives address 255 and alias zero.
// - Address bit 8 is always zero; high code MSB is ignored except by the open check.
// - Fault indicator lights whenever an error condition is detected.
// - Ready lights after initialisation ends and goes off on error.
module nad_top
  import nad_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = NAD_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire nad_levels_t pin_levels,
  input wire logic error_event,
  output logic fault_indicator,
  output logic ready_indicator,
  output logic irq
);

  // The settle counter needs at least one cycle before the pins are sampled.
  if (SETTLE_CYC < 1) begin : g_bad_settle
    $error("SETTLE_CYC must be at least one");
  end

  // ----------------------------------------------------------------------
  // Quantisers
  // ----------------------------------------------------------------------
  nad_codes_t codes;

  nad_quantizer u_q_high (
    .level_mv(pin_levels.high_mv),
    .code(codes.high)
  );
  nad_quantizer u_q_mid (
    .level_mv(pin_levels.mid_mv),
    .code(codes.mid)
  );
  nad_quantizer u_q_low (
    .level_mv(pin_levels.low_mv),
    .code(codes.low)
  );

  // The high weight reaches bit 8, which is then forced to zero.
  function automatic logic [NAD_ADDR_W-1:0] compose_addr(input nad_codes_t c);
    logic [NAD_ADDR_W-1:0] sum;
    sum = NAD_ADDR_W'(NAD_HIGH_WEIGHT * NAD_ADDR_W'(c.high))
        + NAD_ADDR_W'(NAD_MID_WEIGHT * NAD_ADDR_W'(c.mid))
        + NAD_ADDR_W'(c.low);
    sum[NAD_ADDR_TOP_BIT] = 1'b0;
    return sum;
  endfunction

  // All codes zero means every pin is open or grounded.
  logic all_open;
  assign all_open = (codes.high == '0) && (codes.mid == '0) && (codes.low == '0);

  // ----------------------------------------------------------------------
  // Initialisation sequencer
  // ----------------------------------------------------------------------
  nad_state_t state_reg, state_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [NAD_ADDR_W-1:0] addr_reg, addr_next;
  logic open_reg, open_next;
  logic [15:0] alias_reg, alias_next;
  logic err_reg, err_next;
  logic init_done;
  logic sw_err, sw_clr;

  assign init_done = (state_reg == NAD_RUN);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    open_next = open_reg;
    alias_next = alias_reg;
    case (state_reg)
      NAD_SETTLE: begin
        if (cnt_reg == SETTLE_CYC - 1) begin
          state_next = NAD_SAMPLE;
        end else begin
          cnt_next = cnt_reg + 32'h1;
        end
      end
      NAD_SAMPLE: begin
        // The address is captured only here, then held until reset.
        state_next = NAD_RUN;
        if (all_open) begin
          addr_next = NAD_OPEN_ADDR;
          open_next = 1'b1;
          alias_next = NAD_ALIAS_RESET;
        end else begin
          addr_next = compose_addr(codes);
          open_next = 1'b0;
          alias_next = 16'(compose_addr(codes));
        end
      end
      NAD_RUN: begin
        state_next = NAD_RUN;
      end
      default: begin
        state_next = NAD_SETTLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= NAD_SETTLE;
      cnt_reg <= '0;
      addr_reg <= NAD_ADDR_RESET;
      open_reg <= 1'b0;
      alias_reg <= NAD_ALIAS_RESET;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      open_reg <= open_next;
      alias_reg <= alias_next;
    end
  end

  // ----------------------------------------------------------------------
  // Error latch and indicators
  // ----------------------------------------------------------------------
  // An error is sticky until software clears it; a new event wins.
  always_comb begin
    err_next = err_reg;
    if (sw_clr) begin
      err_next = 1'b0;
    end
    if (error_event || sw_err) begin
      err_next = 1'b1;
    end
  end

  // Indicators follow the next latch value so they change with the latch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 1'b0;
      fault_indicator <= 1'b0;
      ready_indicator <= 1'b0;
    end else begin
      err_reg <= err_next;
      fault_indicator <= err_next;
      ready_indicator <= (state_next == NAD_RUN) && !err_next;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------
  logic [NAD_IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [NAD_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [NAD_IRQ_W-1:0] irq_set, irq_w1c;
  logic wr_access;

  assign wr_access = psel && penable && pwrite;
  // Ready and open events are raised once, in the sample cycle.
  assign irq_set[NAD_IRQ_READY_BIT] = (state_reg == NAD_SAMPLE);
  assign irq_set[NAD_IRQ_FAULT_BIT] = err_next && !err_reg;
  assign irq_set[NAD_IRQ_OPEN_BIT] = (state_reg == NAD_SAMPLE) && all_open;
  assign irq_w1c = (wr_access && paddr == NAD_OFS_IRQ_STAT) ?
                   pwdata[NAD_IRQ_W-1:0] : '0;

  always_comb begin
    irq_stat_next = (irq_stat_reg & ~irq_w1c) | irq_set;
    irq_mask_next = irq_mask_reg;
    if (wr_access && paddr == NAD_OFS_IRQ_MASK) begin
      irq_mask_next = pwdata[NAD_IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // The interrupt is a level, high while any unmasked status bit is set.
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Zero wait states; unmapped addresses answer with pslverr.
  logic mapped;
  logic [31:0] rd_mux;

  assign sw_err = wr_access && (paddr == NAD_OFS_CTRL) && pwdata[NAD_CTRL_ERR_BIT];
  assign sw_clr = wr_access && (paddr == NAD_OFS_CTRL) && pwdata[NAD_CTRL_CLR_BIT];
  assign pready = 1'b1;

  always_comb begin
    mapped = 1'b1;
    rd_mux = '0;
    case (paddr)
      NAD_OFS_ADDR: rd_mux = 32'(addr_reg);
      NAD_OFS_STATUS: begin
        rd_mux[NAD_ST_READY_BIT] = ready_indicator;
        rd_mux[NAD_ST_FAULT_BIT] = fault_indicator;
        rd_mux[NAD_ST_OPEN_BIT] = open_reg;
      end
      NAD_OFS_CTRL: rd_mux = '0;
      NAD_OFS_IRQ_STAT: rd_mux = 32'(irq_stat_reg);
      NAD_OFS_IRQ_MASK: rd_mux = 32'(irq_mask_reg);
      NAD_OFS_ALIAS: rd_mux = 32'(alias_reg);
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;
  // Reads return zero outside a read access so the bus stays quiet.
  assign prdata = (psel && penable && !pwrite) ? rd_mux : '0;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // Address and alias checks.
  a_addr_top_zero: assert property (@(posedge pclk) disable iff (!presetn)
    addr_reg[NAD_ADDR_TOP_BIT] == 1'b0) else $error("address bit 8 set");

  a_open_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == NAD_SAMPLE && all_open) |=> (addr_reg == NAD_OPEN_ADDR && alias_reg == '0))
    else $error("open pins did not give 255");

  // An address of 255 cannot come from a weighted sum, so it marks open pins alone.
  a_open_flag: assert property (@(posedge pclk) disable iff (!presetn)
    init_done |-> (open_reg == (addr_reg == NAD_OPEN_ADDR)))
    else $error("open flag and address disagree");

  a_addr_sum: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == NAD_SAMPLE && !all_open) |=>
    addr_reg == (($past(codes.high) & 3'h3) * 9'h040 + $past(codes.mid) * 9'h006
                 + $past(codes.low))) else $error("address sum wrong");

  // Band checks at both ends of the scale.
  a_code_band: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_levels.low_mv <= NAD_BAND_TOP_MV[NAD_MV_W-1:0]) |-> codes.low == 3'h0)
    else $error("lowest band not zero");

  a_code_top: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_levels.high_mv > NAD_BAND_TOP_MV[(NAD_NUM_BANDS-1)*NAD_MV_W +: NAD_MV_W])
    |-> codes.high == 3'h7) else $error("top band not seven");

  // The sequencer waits out the settle count, samples once and then stays in RUN.
  a_settle_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == NAD_SETTLE && cnt_reg != SETTLE_CYC - 1) |=> state_reg == NAD_SETTLE)
    else $error("settle ended early");

  a_run_stays: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == NAD_RUN) |=> (state_reg == NAD_RUN)) else $error("left run state");

  a_addr_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == NAD_RUN) |=> $stable(addr_reg)) else $error("address changed");

  // Indicator checks.
  a_fault_on: assert property (@(posedge pclk) disable iff (!presetn)
    error_event |=> fault_indicator && !ready_indicator)
    else $error("error not shown");

  a_ready_run: assert property (@(posedge pclk) disable iff (!presetn)
    ready_indicator |-> (init_done && !fault_indicator))
    else $error("ready without init");

  sequence s_sampled;
    state_reg == NAD_SAMPLE ##1 !err_reg;
  endsequence
  a_ready_after: assert property (@(posedge pclk) disable iff (!presetn)
    s_sampled |-> ready_indicator) else $error("ready not lit");

  // A software clear with no new error in the same cycle relights ready.
  sequence s_sw_clear;
    init_done && sw_clr && !sw_err && !error_event;
  endsequence
  a_clear_ready: assert property (@(posedge pclk) disable iff (!presetn)
    s_sw_clear |=> !fault_indicator && ready_indicator)
    else $error("clear did not relight ready");

  // Writing one to the fault status bit clears it unless a new fault arrives.
  a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_w1c[NAD_IRQ_FAULT_BIT] && !irq_set[NAD_IRQ_FAULT_BIT])
    |=> !irq_stat_reg[NAD_IRQ_FAULT_BIT]) else $error("fault status not cleared");

endmodule // nad_top

// file: bench/nad_strap_model.sv
// Purpose: Board straps that set the level on each address select pin.
// Assumes: A code picks the band; at_edge picks its top edge, else its nominal level.
// Notes: A code of zero drives 0 mV, or 530 mV with at_edge; both read as an open or grounded pin.
module nad_strap_model
  import nad_pkg::*;
(
  input wire nad_codes_t codes,
  input wire logic at_edge,
  output nad_levels_t levels
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] NOM_MV [8] = '{12'h000, 12'h424, 12'h6E0, 12'h8CA,
    12'hA28, 12'hB4A, 12'hC3A, 12'hCE4};
  localparam logic [11:0] TOP_MV [8] = '{12'h212, 12'h582, 12'h7DA, 12'h97E,
    12'hABE, 12'hBC2, 12'hC94, 12'hCE4};

  always_comb begin
    levels.high_mv = at_edge ? TOP_MV[codes.high] : NOM_MV[codes.high];
    levels.mid_mv = at_edge ? TOP_MV[codes.mid] : NOM_MV[codes.mid];
    levels.low_mv = at_edge ? TOP_MV[codes.low] : NOM_MV[codes.low];
  end
endmodule // nad_strap_model

// file: bench/test_node_address_pin_decoder.sv
// Purpose: Self-checking bench for the node address pin decoder.
// Assumes: The APB slave ends each access when pready is high; settle count is 4 cycles.
// Notes: Each strap setting is applied under reset, then read back.
module test_node_address_pin_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  import nad_pkg::*;
  localparam int unsigned SETTLE = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  nad_levels_t levels;
  logic error_event = 1'b0;
  logic fault_indicator;
  logic ready_indicator;
  logic irq;
  nad_codes_t codes = '0;
  logic at_edge = 1'b0;
  int n_fail = 0;
  int n_compared = 0;
  nad_codes_t c;
  logic [31:0] ea;

  always #2 pclk = ~pclk;

  nad_strap_model straps (.codes(codes), .at_edge(at_edge), .levels(levels));
  nad_top #(.SETTLE_CYC(SETTLE)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_levels(levels), .error_event(error_event),
    .fault_indicator(fault_indicator), .ready_indicator(ready_indicator), .irq(irq));

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rdat, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 32);
    if (n >= 32) n_fail++;
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
    chk("pslverr", 32'(exp_err), 32'(e));
  endtask

  task automatic restart(input nad_codes_t s, input logic e, input int hold);
    codes <= s;
    at_edge <= e;
    presetn <= 1'b0;
    repeat (hold) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1 chk("ready early", 32'h0, 32'(ready_indicator));
    repeat (SETTLE + 4) @(posedge pclk);
    chk("indicators", 32'h1, 32'({fault_indicator, ready_indicator}));
  endtask

  function automatic logic [31:0] exp_addr(input nad_codes_t s);
    logic [8:0] a;
    a = 9'(64 * s.high + 6 * s.mid + s.low);
    a[8] = 1'b0;
    if (s == '0) a = 9'h0FF;
    return {23'h0, a};
  endfunction

  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    #20000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    for (int i = 0; i <= 8; i++) begin
      c = (i == 8) ? '0 : nad_codes_t'{high: 3'(i), mid: 3'(i + 3), low: 3'(7 - i)};
      ea = exp_addr(c);
      restart(c, i[0], (i == 0) ? 16 : 2);
      rd_chk("address", NAD_OFS_ADDR, ea, 1'b0);
      rd_chk("alias", NAD_OFS_ALIAS, (c == '0) ? 32'h0 : ea, 1'b0);
      rd_chk("status", NAD_OFS_STATUS, {29'h0, c == '0, 2'b01}, 1'b0);
      codes <= ~c;
      repeat (4) @(posedge pclk);
      rd_chk("held address", NAD_OFS_ADDR, ea, 1'b0);
    end
    wr(NAD_OFS_ADDR, 32'h000001FF);
    rd_chk("read only address", NAD_OFS_ADDR, 32'h000000FF, 1'b0);
    rd_chk("unmapped", 8'h40, 32'h0, 1'b1);
    rd_chk("irq status", NAD_OFS_IRQ_STAT, 32'h5, 1'b0);
    wr(NAD_OFS_IRQ_STAT, 32'h7);
    rd_chk("irq cleared", NAD_OFS_IRQ_STAT, 32'h0, 1'b0);
    wr(NAD_OFS_IRQ_MASK, 32'h2);
    rd_chk("irq mask", NAD_OFS_IRQ_MASK, 32'h2, 1'b0);
    chk("irq idle", 32'h0, 32'(irq));
    error_event <= 1'b1;
    @(posedge pclk);
    error_event <= 1'b0;
    #1 chk("error pin", 32'h2, 32'({fault_indicator, ready_indicator}));
    chk("irq fault", 32'h1, 32'(irq));
    @(posedge pclk);
    wr(NAD_OFS_IRQ_STAT, 32'h2);
    chk("irq after clear", 32'h0, 32'(irq));
    wr(NAD_OFS_CTRL, 32'h2);
    chk("fault cleared", 32'h0, 32'(fault_indicator));
    wr(NAD_OFS_CTRL, 32'h1);
    chk("error ctrl", 32'h2, 32'({fault_indicator, ready_indicator}));
    chk("irq again", 32'h1, 32'(irq));
    rd_chk("status fault", NAD_OFS_STATUS, 32'h6, 1'b0);
    report_and_stop();
  end
endmodule // test_node_address_pin_decoder
